// *** rtl/oau_top.v ***
// operand addressing unit: resolves addressing modes and effective addresses
// assumes decode presents one instruction per valid cycle and the register
// file presents the selected pointer and base values in that same cycle
// limitation: there is no stall input; the clock enable is the only hold
`timescale 1ns/1ps
`include "oau_regs.vh"

module oau_top (
	input wire clk_i,
	input wire rst_i,
	input wire ce_i,
	input wire valid_i,
	input wire [2:0] iclass_i,
	input wire [2:0] amode_i,
	input wire [15:0] faddr_i,
	input wire [9:0] lit_i,
	input wire lit_wide_i,
	input wire dec_i,
	input wire byte_i,
	input wire [3:0] ptr_sel_i,
	input wire [3:0] base_sel_i,
	input wire [3:0] dst_sel_i,
	input wire dst_default_working_register_i,
	input wire dst_mem_i,
	input wire dst_pair_i,
	input wire [15:0] ptr_val_i,
	input wire [15:0] base_val_i,
	output wire out_valid_o,
	output wire illegal_o,
	output wire [1:0] src_kind_o,
	output wire [15:0] ea_o,
	output wire mem_rd_o,
	output wire [3:0] src_reg_o,
	output wire [3:0] base_reg_o,
	output wire base_use_o,
	output wire [15:0] lit_o,
	output wire [3:0] dst_reg_o,
	output wire dst_is_mem_o,
	output wire dst_pair_o,
	output wire [15:0] dst_ea_o,
	output wire ptr_we_o,
	output wire [3:0] ptr_wsel_o,
	output wire [15:0] ptr_wval_o
);

	// ==========================================================
	// next-state and register declarations
	// strobes and data fields are kept apart: strobes clear on idle
	// cycles, data fields only move when an instruction is taken
	reg out_valid_q;
	reg illegal_q, illegal_d;
	reg [1:0] src_kind_q, src_kind_d;
	reg [15:0] ea_q, ea_d;
	reg mem_rd_q, mem_rd_d;
	reg [3:0] src_reg_q, src_reg_d;
	reg [3:0] base_reg_q, base_reg_d;
	reg base_use_q, base_use_d;
	reg [15:0] lit_q, lit_d;
	reg [3:0] dst_reg_q, dst_reg_d;
	reg dst_is_mem_q, dst_is_mem_d;
	reg dst_pair_q, dst_pair_d;
	reg [15:0] dst_ea_q, dst_ea_d;
	reg ptr_we_q, ptr_we_d;
	reg [3:0] ptr_wsel_q, ptr_wsel_d;
	reg [15:0] ptr_wval_q, ptr_wval_d;
	wire legal;
	wire [15:0] gen_ea;
	wire [15:0] gen_ptr;

	// zero-extend a literal to the data width
	// masking here, not at the port, keeps the 10-bit path for transfers
	function [15:0] oau_zext;
		input [9:0] v;
		input wide;
		begin
			if (wide) begin
				oau_zext = {6'h00, v};
			end else begin
				oau_zext = {6'h00, v & `OAU_LIT5_MASK};
			end
		end
	endfunction

	// true for the forms that read data memory through a pointer
	// used to keep an illegal pointer form from writing a moved value back
	function oau_is_ind;
		input [2:0] m;
		begin
			oau_is_ind = (m == `OAU_AM_IND) || (m == `OAU_AM_POST) ||
				(m == `OAU_AM_PRE) || (m == `OAU_AM_INDEXED) ||
				(m == `OAU_AM_LITOFF);
		end
	endfunction

	// ==========================================================
	// helpers: mode table and address arithmetic
	// the table sits apart so the mode set of each class lives in one place
	// one adder path serves every pointer form, traded against a deeper cone
	oau_legal u_legal (
		.iclass_i(iclass_i),
		.amode_i(amode_i),
		.lit_wide_i(lit_wide_i),
		.legal_o(legal)
	);

	oau_eagen u_eagen (
		.amode_i(amode_i),
		.ptr_val_i(ptr_val_i),
		.base_val_i(base_val_i),
		.lit_i(lit_i),
		.dec_i(dec_i),
		.byte_i(byte_i),
		.ea_o(gen_ea),
		.ptr_new_o(gen_ptr)
	);

	// ==========================================================
	// operand source decode
	// defaults describe an idle slot: no source and no memory access
	always @* begin
		src_kind_d = `OAU_SRC_NONE;
		ea_d = `OAU_RST_WORD;
		mem_rd_d = 1'b0;
		src_reg_d = `OAU_RST_SEL;
		lit_d = `OAU_RST_WORD;
		case (amode_i)
			// address straight from the instruction, no register in it
			`OAU_AM_FILEDIR: begin
				src_kind_d = `OAU_SRC_MEM;
				mem_rd_d = 1'b1;
				if (iclass_i == `OAU_CL_MOVE) begin
					ea_d = faddr_i;
				end else begin
					ea_d = faddr_i & `OAU_NEAR_MASK;
				end
			end
			// register itself is the operand; memory untouched
			`OAU_AM_REGDIR: begin
				src_kind_d = `OAU_SRC_REG;
				src_reg_d = ptr_sel_i;
			end
			// literal carried in the instruction
			`OAU_AM_LIT: begin
				src_kind_d = `OAU_SRC_LIT;
				lit_d = oau_zext(lit_i, lit_wide_i);
			end
			`OAU_AM_IND, `OAU_AM_POST, `OAU_AM_PRE: begin
				src_kind_d = `OAU_SRC_MEM;
				mem_rd_d = 1'b1;
				ea_d = gen_ea;
			end
			`OAU_AM_INDEXED, `OAU_AM_LITOFF: begin
				src_kind_d = `OAU_SRC_MEM;
				mem_rd_d = 1'b1;
				ea_d = gen_ea;
			end
			default: begin
				src_kind_d = `OAU_SRC_NONE;
			end
		endcase
		// an illegal encoding must not touch memory
		// the destination and pointer strobes are gated the same way
		if (!legal) begin
			mem_rd_d = 1'b0;
		end
	end

	// ==========================================================
	// implicit and base operand decode
	// the base selector passes even when unused; base_use says if it counts
	always @* begin
		base_reg_d = `OAU_RST_SEL;
		base_use_d = 1'b0;
		case (iclass_i)
			// file class works against register zero
			`OAU_CL_FILE, `OAU_CL_PROD: begin
				base_reg_d = `OAU_DEFAULT_WORKING_REGISTER_ZERO;
				base_use_d = 1'b1;
			end
			// first source is always a register, read directly
			`OAU_CL_MCU3: begin
				base_reg_d = base_sel_i;
				base_use_d = 1'b1;
			end
			// base register only feeds the indexed address
			`OAU_CL_MOVE, `OAU_CL_DSP: begin
				base_reg_d = base_sel_i;
				base_use_d = (amode_i == `OAU_AM_INDEXED);
			end
			default: begin
				base_use_d = 1'b0;
			end
		endcase
	end

	// ==========================================================
	// destination decode
	// transfer and three-operand share the memory result at the operand ea
	// limitation: a memory result elsewhere than the operand ea is not offered
	always @* begin
		dst_reg_d = `OAU_RST_SEL;
		dst_is_mem_d = 1'b0;
		dst_pair_d = 1'b0;
		dst_ea_d = `OAU_RST_WORD;
		case (iclass_i)
			// back to the same file register or to register zero
			`OAU_CL_FILE: begin
				if (dst_default_working_register_i) begin
					dst_reg_d = `OAU_DEFAULT_WORKING_REGISTER_ZERO;
				end else begin
					dst_is_mem_d = 1'b1;
					dst_ea_d = faddr_i & `OAU_NEAR_MASK;
				end
			end
			// product ignores the file/zero choice
			`OAU_CL_PROD: begin
				dst_reg_d = dst_sel_i;
				dst_pair_d = dst_pair_i;
			end
			// register or memory result, memory at the operand address
			`OAU_CL_MCU3, `OAU_CL_MOVE: begin
				dst_reg_d = dst_sel_i;
				dst_is_mem_d = dst_mem_i;
				dst_ea_d = dst_mem_i ? ea_d : `OAU_RST_WORD;
			end
			// accumulate class results stay in registers
			`OAU_CL_DSP: begin
				dst_reg_d = dst_sel_i;
			end
			default: begin
				dst_reg_d = `OAU_RST_SEL;
			end
		endcase
		if (!legal) begin
			dst_is_mem_d = 1'b0;
		end
	end

	// ==========================================================
	// pointer write-back and illegal flag
	// gating by legal keeps an illegal post or pre form from moving the
	// pointer, so control logic can retry without repairing the register
	always @* begin
		illegal_d = !legal;
		ptr_wsel_d = ptr_sel_i;
		ptr_wval_d = gen_ptr;
		// only post and pre forms move the pointer
		ptr_we_d = legal && ((amode_i == `OAU_AM_POST) ||
			(amode_i == `OAU_AM_PRE));
		// an illegal pointer-based form puts the unmoved pointer value on the write-back data
		if (oau_is_ind(amode_i) && !legal) begin
			ptr_wval_d = ptr_val_i;
		end
	end

	// ==========================================================
	// output registers; hold everything while clock enable is low
	// strobes clear on idle cycles so a held decode never repeats a memory
	// read or a pointer write; data fields keep their last value because
	// downstream logic may still be reading them a cycle later
	// the reset values match an idle slot, so release needs no warm-up
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			out_valid_q <= 1'b0;
			illegal_q <= 1'b0;
			src_kind_q <= `OAU_SRC_NONE;
			ea_q <= `OAU_RST_WORD;
			mem_rd_q <= 1'b0;
			src_reg_q <= `OAU_RST_SEL;
			base_reg_q <= `OAU_RST_SEL;
			base_use_q <= 1'b0;
			lit_q <= `OAU_RST_WORD;
			dst_reg_q <= `OAU_RST_SEL;
			dst_is_mem_q <= 1'b0;
			dst_pair_q <= 1'b0;
			dst_ea_q <= `OAU_RST_WORD;
			ptr_we_q <= 1'b0;
			ptr_wsel_q <= `OAU_RST_SEL;
			ptr_wval_q <= `OAU_RST_WORD;
		end else if (ce_i) begin
			out_valid_q <= valid_i;
			// strobes qualified by valid so idle cycles stay quiet
			illegal_q <= valid_i && illegal_d;
			mem_rd_q <= valid_i && mem_rd_d;
			ptr_we_q <= valid_i && ptr_we_d;
			dst_is_mem_q <= valid_i && dst_is_mem_d;
			base_use_q <= valid_i && base_use_d;
			// data fields only reload on a valid instruction
			if (valid_i) begin
				src_kind_q <= src_kind_d;
				ea_q <= ea_d;
				src_reg_q <= src_reg_d;
				base_reg_q <= base_reg_d;
				lit_q <= lit_d;
				dst_reg_q <= dst_reg_d;
				dst_pair_q <= dst_pair_d;
				dst_ea_q <= dst_ea_d;
				ptr_wsel_q <= ptr_wsel_d;
				ptr_wval_q <= ptr_wval_d;
			end
		end
	end

	// ==========================================================
	// outputs straight from flip-flops
	// no logic between the flops and the pins keeps port timing clean
	assign out_valid_o = out_valid_q;
	assign illegal_o = illegal_q;
	assign src_kind_o = src_kind_q;
	assign ea_o = ea_q;
	assign mem_rd_o = mem_rd_q;
	assign src_reg_o = src_reg_q;
	assign base_reg_o = base_reg_q;
	assign base_use_o = base_use_q;
	assign lit_o = lit_q;
	assign dst_reg_o = dst_reg_q;
	assign dst_is_mem_o = dst_is_mem_q;
	assign dst_pair_o = dst_pair_q;
	assign dst_ea_o = dst_ea_q;
	assign ptr_we_o = ptr_we_q;
	assign ptr_wsel_o = ptr_wsel_q;
	assign ptr_wval_o = ptr_wval_q;

endmodule // oau_top

// *** rtl/oau_regs.vh ***
// constants shared by the operand addressing unit files
// assumes inclusion by bare name from files under rtl/
`ifndef OAU_REGS_VH
`define OAU_REGS_VH

// ==========================================================
// instruction classes
`define OAU_CL_FILE 3'h0
`define OAU_CL_MCU3 3'h1
`define OAU_CL_MOVE 3'h2
`define OAU_CL_PROD 3'h3
`define OAU_CL_DSP 3'h4

// ==========================================================
// addressing modes
`define OAU_AM_REGDIR 3'h0
`define OAU_AM_IND 3'h1
`define OAU_AM_POST 3'h2
`define OAU_AM_PRE 3'h3
`define OAU_AM_INDEXED 3'h4
`define OAU_AM_LITOFF 3'h5
`define OAU_AM_LIT 3'h6
`define OAU_AM_FILEDIR 3'h7

// ==========================================================
// second operand source codes
`define OAU_SRC_REG 2'h0
`define OAU_SRC_MEM 2'h1
`define OAU_SRC_LIT 2'h2
`define OAU_SRC_NONE 2'h3

// ==========================================================
// field widths, masks and fixed values
`define OAU_NEAR_AW 13
`define OAU_NEAR_MASK 16'h1fff
`define OAU_LIT5_MASK 10'h01f
`define OAU_DEFAULT_WORKING_REGISTER_ZERO 4'h0
`define OAU_STEP_BYTE 16'h0001
`define OAU_STEP_WORD 16'h0002
`define OAU_RST_WORD 16'h0000
`define OAU_RST_SEL 4'h0
`define OAU_LATENCY 1

`endif

// *** rtl/oau_legal.v ***
// legality table: which addressing modes each instruction class accepts
// assumes class and mode codes from oau_regs.vh; purely combinational
`timescale 1ns/1ps
`include "oau_regs.vh"

module oau_legal (
	input wire [2:0] iclass_i,
	input wire [2:0] amode_i,
	input wire lit_wide_i,
	output reg legal_o
);

	// ==========================================================
	// per-class mode subsets
	always @* begin
		legal_o = 1'b0;
		case (iclass_i)
			`OAU_CL_FILE: legal_o = (amode_i == `OAU_AM_FILEDIR);
			`OAU_CL_PROD: legal_o = (amode_i == `OAU_AM_FILEDIR);
			// three-operand: no indexed or offset forms, 5-bit literal only
			`OAU_CL_MCU3: begin
				legal_o = (amode_i == `OAU_AM_REGDIR) || (amode_i == `OAU_AM_IND) ||
					(amode_i == `OAU_AM_POST) || (amode_i == `OAU_AM_PRE) ||
					((amode_i == `OAU_AM_LIT) && !lit_wide_i);
			end
			// data transfer accepts every form
			`OAU_CL_MOVE: legal_o = 1'b1;
			// accumulate class has its own small set
			`OAU_CL_DSP: begin
				legal_o = (amode_i == `OAU_AM_IND) || (amode_i == `OAU_AM_POST) ||
					(amode_i == `OAU_AM_INDEXED);
			end
			default: legal_o = 1'b0;
		endcase
	end

endmodule // oau_legal

// *** rtl/oau_eagen.v ***
// effective-address and pointer update arithmetic
// assumes pointer and base values arrive already read from the register file
`timescale 1ns/1ps
`include "oau_regs.vh"

module oau_eagen (
	input wire [2:0] amode_i,
	input wire [15:0] ptr_val_i,
	input wire [15:0] base_val_i,
	input wire [9:0] lit_i,
	input wire dec_i,
	input wire byte_i,
	output reg [15:0] ea_o,
	output reg [15:0] ptr_new_o
);

	// signed step of one byte or one word
	function [15:0] oau_step;
		input dec;
		input bsz;
		reg [15:0] mag;
		begin
			mag = bsz ? `OAU_STEP_BYTE : `OAU_STEP_WORD;
			oau_step = dec ? (16'h0000 - mag) : mag;
		end
	endfunction

	// ==========================================================
	// address forming; pointer only moves in post/pre forms
	always @* begin
		ea_o = ptr_val_i;
		ptr_new_o = ptr_val_i;
		case (amode_i)
			`OAU_AM_IND: ea_o = ptr_val_i;
			`OAU_AM_POST: begin
				ea_o = ptr_val_i;
				ptr_new_o = ptr_val_i + oau_step(dec_i, byte_i);
			end
			`OAU_AM_PRE: begin
				ptr_new_o = ptr_val_i + oau_step(dec_i, byte_i);
				ea_o = ptr_new_o;
			end
			`OAU_AM_INDEXED: ea_o = ptr_val_i + base_val_i;
			// literal offset is signed, sign-extended from 10 bits
			`OAU_AM_LITOFF: ea_o = ptr_val_i + {{6{lit_i[9]}}, lit_i};
			default: ea_o = ptr_val_i;
		endcase
	end

endmodule // oau_eagen

// *** test/oau_top_asserts.sv ***
// port checker for the operand addressing unit
// assumes oau_regs.vh on the include path and one instruction per valid cycle
`timescale 1ns/1ps
`include "oau_regs.vh"

// ==========================================================
// checker module
module oau_top_asserts (
	input wire clk_i,
	input wire rst_i,
	input wire ce_i,
	input wire valid_i,
	input wire [2:0] iclass_i,
	input wire [2:0] amode_i,
	input wire [15:0] faddr_i,
	input wire dec_i,
	input wire byte_i,
	input wire [15:0] ptr_val_i,
	input wire [15:0] base_val_i,
	input wire out_valid_o,
	input wire illegal_o,
	input wire [15:0] ea_o,
	input wire mem_rd_o,
	input wire [3:0] base_reg_o,
	input wire ptr_we_o,
	input wire [15:0] ptr_wval_o,
	input wire dst_is_mem_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// taken instruction, shared by every antecedent except the idle, freeze and illegal checks
	wire tk = ce_i && valid_i;
	wire mv = tk && iclass_i == `OAU_CL_MOVE;

	a_answer_one_cycle: assert property (tk |=> out_valid_o)
		else $error("taken instruction gave no answer");
	a_no_spurious_out: assert property (ce_i && !valid_i |=> !out_valid_o)
		else $error("answer without a taken instruction");
	a_freeze_hold: assert property (!ce_i |=> $stable(out_valid_o) && $stable(ea_o))
		else $error("state moved while clock enable was low");
	a_offset_keep: assert property (mv && amode_i == `OAU_AM_LITOFF |=> !ptr_we_o)
		else $error("offset form moved the pointer");
	a_illegal_quiet: assert property (illegal_o |-> !mem_rd_o && !ptr_we_o && !dst_is_mem_o)
		else $error("illegal op caused side effects");
	a_file_near: assert property (tk && iclass_i == `OAU_CL_FILE && amode_i == `OAU_AM_FILEDIR
		|=> ea_o == {3'h0, $past(faddr_i[12:0])} && base_reg_o == 4'h0)
		else $error("file direct address wrong");
	a_indir_ea: assert property (mv && amode_i == `OAU_AM_IND
		|=> ea_o == $past(ptr_val_i) && mem_rd_o)
		else $error("indirect address wrong");
	a_post_step: assert property (mv && amode_i == `OAU_AM_POST && !dec_i && !byte_i
		|=> ptr_we_o && ea_o == $past(ptr_val_i) && ptr_wval_o == ea_o + 16'h0002)
		else $error("post step wrong");
	a_pre_step: assert property (mv && amode_i == `OAU_AM_PRE && dec_i && byte_i
		|=> ptr_we_o && ea_o == $past(ptr_val_i) - 16'h0001 && ptr_wval_o == ea_o)
		else $error("pre step wrong");
	a_index_keep: assert property (mv && amode_i == `OAU_AM_INDEXED
		|=> ea_o == $past(ptr_val_i) + $past(base_val_i) && !ptr_we_o)
		else $error("indexed address wrong");
	a_dsp_no_lit: assert property (tk && iclass_i == `OAU_CL_DSP && amode_i == `OAU_AM_LIT
		|=> illegal_o)
		else $error("accumulate literal not flagged");
	a_regdir_no_mem: assert property (tk && iclass_i == `OAU_CL_MCU3 && amode_i == `OAU_AM_REGDIR
		|=> !mem_rd_o && !illegal_o)
		else $error("register direct touched memory");
endmodule // oau_top_asserts

bind oau_top oau_top_asserts oau_top_asserts_i (.clk_i, .rst_i, .ce_i, .valid_i, .iclass_i,
	.amode_i, .faddr_i, .dec_i, .byte_i, .ptr_val_i, .base_val_i, .out_valid_o, .illegal_o,
	.ea_o, .mem_rd_o, .base_reg_o, .ptr_we_o, .ptr_wval_o, .dst_is_mem_o);

// *** test/oau_wfile.sv ***
// working register file model facing the addressing unit
// assumes reads are combinational and write-back lands one edge after the strobe
`timescale 1ns/1ps

// ==========================================================
// register file model
module oau_wfile (
	input wire clk_i,
	input wire rst_i,
	input wire [3:0] rd_a_i,
	input wire [3:0] rd_b_i,
	input wire we_i,
	input wire [3:0] wsel_i,
	input wire [15:0] wval_i,
	output wire [15:0] rd_a_o,
	output wire [15:0] rd_b_o
);
	logic [15:0] w_q [16];
	// distinct reset contents so a wrong selector shows up in the address
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int n = 0; n < 16; n++) w_q[n] <= 16'h1000 + 16'(n << 8);
		end else if (we_i) begin
			w_q[wsel_i] <= wval_i;
		end
	end
	// reads are same-cycle, as the unit expects
	assign rd_a_o = w_q[rd_a_i];
	assign rd_b_o = w_q[rd_b_i];
endmodule // oau_wfile

// *** test/testbench.sv ***
// self-checking bench for the operand addressing unit
// assumes the register file model resets register n to 16'h1000 + n * 16'h0100
`timescale 1ns/1ps
`include "oau_regs.vh"

module testbench;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce_i = 1'b1, valid_i = 1'b0, lit_wide_i = 1'b0, dec_i = 1'b0, byte_i = 1'b0;
	logic dst_default_working_register_i = 1'b0, dst_mem_i = 1'b0, dst_pair_i = 1'b0;
	logic [2:0] iclass_i = 3'h0, amode_i = 3'h0;
	logic [15:0] faddr_i = 16'h0000;
	logic [9:0] lit_i = 10'h000;
	logic [3:0] ptr_sel_i = 4'h0, base_sel_i = 4'h0, dst_sel_i = 4'h0;
	logic [15:0] ptr_val_i, base_val_i, ea_o, lit_o, dst_ea_o, ptr_wval_o;
	logic out_valid_o, illegal_o, mem_rd_o, base_use_o, dst_is_mem_o, dst_pair_o, ptr_we_o;
	logic [1:0] src_kind_o;
	logic [3:0] src_reg_o, base_reg_o, dst_reg_o, ptr_wsel_o;
	int miscompares = 0;
	int n_compared = 0;
	int cycles = 0;

	// ==========================================================
	// design, register file model, clock and watchdog
	oau_top oau_top_i (.clk_i, .rst_i, .ce_i, .valid_i, .iclass_i, .amode_i, .faddr_i, .lit_i,
		.lit_wide_i, .dec_i, .byte_i, .ptr_sel_i, .base_sel_i, .dst_sel_i, .dst_default_working_register_i,
		.dst_mem_i, .dst_pair_i, .ptr_val_i, .base_val_i, .out_valid_o, .illegal_o,
		.src_kind_o, .ea_o, .mem_rd_o, .src_reg_o, .base_reg_o, .base_use_o, .lit_o,
		.dst_reg_o, .dst_is_mem_o, .dst_pair_o, .dst_ea_o, .ptr_we_o, .ptr_wsel_o, .ptr_wval_o);
	oau_wfile oau_wfile_i (.clk_i, .rst_i, .rd_a_i(ptr_sel_i), .rd_b_i(base_sel_i),
		.we_i(ptr_we_o), .wsel_i(ptr_wsel_o), .wval_i(ptr_wval_o), .rd_a_o(ptr_val_i),
		.rd_b_o(base_val_i));
	always #50 clk_i = ~clk_i;
	// the whole run needs under a hundred cycles
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			tally_and_finish();
		end
	end

	// ==========================================================
	// shared tasks
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// first edge lets the previous pointer write-back land; results are
	// looked at in the cycle after the taken edge, while the strobes stand
	task automatic go(input logic [2:0] c, input logic [2:0] m);
		@(posedge clk_i);
		#1 iclass_i = c;
		amode_i = m;
		valid_i = 1'b1;
		@(posedge clk_i);
		#1 valid_i = 1'b0;
		chk("out_valid", {15'h0, out_valid_o}, 16'h0001);
	endtask
	task automatic ill(input logic exp);
		chk("illegal", {15'h0, illegal_o}, {15'h0, exp});
	endtask

	// ==========================================================
	// scenarios
	task automatic t_file;
		faddr_i = 16'hffff;
		dst_default_working_register_i = 1'b1;
		ptr_sel_i = 4'h3;
		go(`OAU_CL_FILE, `OAU_AM_FILEDIR);
		chk("file ea", ea_o, 16'h1fff);
		chk("file dst", {12'h0, dst_reg_o}, 16'h0000);
		chk("file base", {12'h0, base_reg_o}, 16'h0000);
		ill(1'b0);
		dst_default_working_register_i = 1'b0;
		go(`OAU_CL_FILE, `OAU_AM_FILEDIR);
		chk("file dst mem", {15'h0, dst_is_mem_o}, 16'h0001);
		chk("file dst ea", dst_ea_o, 16'h1fff);
	endtask
	task automatic t_prod;
		dst_pair_i = 1'b1;
		dst_sel_i = 4'h6;
		go(`OAU_CL_PROD, `OAU_AM_FILEDIR);
		chk("pair", {15'h0, dst_pair_o}, 16'h0001);
		chk("prod dst", {12'h0, dst_reg_o}, 16'h0006);
		go(`OAU_CL_PROD, `OAU_AM_IND);
		ill(1'b1);
		chk("ill rd", {15'h0, mem_rd_o}, 16'h0000);
		dst_pair_i = 1'b0;
	endtask
	task automatic t_far;
		faddr_i = 16'hc0de;
		go(`OAU_CL_MOVE, `OAU_AM_FILEDIR);
		chk("far ea", ea_o, 16'hc0de);
	endtask
	task automatic t_mcu;
		base_sel_i = 4'h5;
		ptr_sel_i = 4'h1;
		go(`OAU_CL_MCU3, `OAU_AM_REGDIR);
		chk("base use", {15'h0, base_use_o}, 16'h0001);
		chk("base reg", {12'h0, base_reg_o}, 16'h0005);
		chk("src reg", {12'h0, src_reg_o}, 16'h0001);
		lit_i = 10'h3ff;
		go(`OAU_CL_MCU3, `OAU_AM_LIT);
		chk("lit5", lit_o, 16'h001f);
		chk("lit kind", {14'h0, src_kind_o}, 16'h0002);
		lit_wide_i = 1'b1;
		go(`OAU_CL_MCU3, `OAU_AM_LIT);
		ill(1'b1);
		lit_wide_i = 1'b0;
		dst_mem_i = 1'b1;
		ptr_sel_i = 4'h7;
		go(`OAU_CL_MCU3, `OAU_AM_IND);
		chk("mem kind", {14'h0, src_kind_o}, 16'h0001);
		chk("mem rd", {15'h0, mem_rd_o}, 16'h0001);
		chk("dst mem", {15'h0, dst_is_mem_o}, 16'h0001);
		chk("dst ea", dst_ea_o, 16'h1700);
		dst_mem_i = 1'b0;
	endtask
	task automatic t_modes;
		ptr_sel_i = 4'h2;
		base_sel_i = 4'h4;
		go(`OAU_CL_MOVE, `OAU_AM_POST);
		chk("post ea", ea_o, 16'h1200);
		chk("post wsel", {12'h0, ptr_wsel_o}, 16'h0002);
		chk("post we", {15'h0, ptr_we_o}, 16'h0001);
		chk("post wval", ptr_wval_o, 16'h1202);
		byte_i = 1'b1;
		dec_i = 1'b1;
		go(`OAU_CL_MOVE, `OAU_AM_PRE);
		chk("pre ea", ea_o, 16'h1201);
		byte_i = 1'b0;
		dec_i = 1'b0;
		go(`OAU_CL_MOVE, `OAU_AM_INDEXED);
		chk("idx ea", ea_o, 16'h2601);
		lit_i = 10'h3fe;
		go(`OAU_CL_MOVE, `OAU_AM_LITOFF);
		chk("off ea", ea_o, 16'h11ff);
		chk("off we", {15'h0, ptr_we_o}, 16'h0000);
		go(`OAU_CL_MOVE, `OAU_AM_IND);
		chk("ind ea", ea_o, 16'h1201);
		chk("ind rd", {15'h0, mem_rd_o}, 16'h0001);
	endtask
	task automatic t_legal;
		logic [2:0] ok [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6};
		foreach (ok[k]) begin
			go(`OAU_CL_MCU3, ok[k]);
			ill(1'b0);
		end
		go(`OAU_CL_DSP, `OAU_AM_LIT);
		ill(1'b1);
		go(`OAU_CL_DSP, `OAU_AM_INDEXED);
		ill(1'b0);
	endtask
	// back to back, then a frozen cycle with the enable low
	task automatic t_back;
		@(posedge clk_i);
		#1 iclass_i = `OAU_CL_MOVE;
		amode_i = `OAU_AM_FILEDIR;
		faddr_i = 16'h0100;
		valid_i = 1'b1;
		@(posedge clk_i);
		#1 faddr_i = 16'h0200;
		chk("b2b ea1", ea_o, 16'h0100);
		@(posedge clk_i);
		#1 ce_i = 1'b0;
		faddr_i = 16'h0300;
		chk("b2b ea2", ea_o, 16'h0200);
		@(posedge clk_i);
		#1 chk("frozen valid", {15'h0, out_valid_o}, 16'h0001);
		chk("frozen ea", ea_o, 16'h0200);
		valid_i = 1'b0;
		ce_i = 1'b1;
		@(posedge clk_i);
		#1 chk("idle", {15'h0, out_valid_o}, 16'h0000);
	endtask

	// ==========================================================
	// verdict and main sequence
	task automatic tally_and_finish;
		if (miscompares == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk_i);
		#1 rst_i = 1'b0;
		t_file();
		t_prod();
		t_far();
		t_mcu();
		t_modes();
		t_legal();
		t_back();
		tally_and_finish();
	end
endmodule // testbench
